// >>> link_codec_pkg.sv
package link_codec_pkg;

   typedef enum logic [1:0] {
      WIDTH_8    = 2'h0,
      WIDTH_9    = 2'h1,
      WIDTH_10   = 2'h2,
      WIDTH_RSVD = 2'h3
   } width_t;

   typedef enum logic [1:0] {
      MODE_LOCAL   = 2'h0,
      MODE_CASCADE = 2'h1,
      MODE_TEST    = 2'h2,
      MODE_RSVD    = 2'h3
   } link_mode_t;

   typedef struct packed {
      width_t     width;
      link_mode_t mode;
   } line_cfg_t;

   typedef struct packed {
      logic        is_cmd;
      logic [11:0] lines;
   } rx_word_t;

   typedef struct packed {
      logic     ok;
      rx_word_t word;
   } dec_t;

   localparam int          LINE_COUNT         = 12;
   localparam int          BIT_CYCLES_DEFAULT = 4;
   localparam logic [3:0]  CODE_BITS          = 4'hc;
   localparam logic [3:0]  LEN_8              = 4'ha;
   localparam logic [3:0]  LEN_9              = 4'hb;
   localparam logic [3:0]  LEN_10             = 4'hc;
   localparam logic [11:0] LINES_RESET        = 12'h000;
   localparam logic        LINE_IDLE_LEVEL    = 1'b0;
   localparam logic [4:0]  SYM_J              = 5'h18;
   localparam logic [4:0]  SYM_K              = 5'h11;

   localparam logic [4:0] ENC4_TABLE [16] = '{
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

   localparam logic [5:0] ENC5_TABLE [32] = '{
      6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
      6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
      6'h3e, 6'h19, 6'h29, 6'h2d, 6'h1a, 6'h1b, 6'h1e, 6'h1f,
      6'h2a, 6'h2b, 6'h2e, 6'h2f, 6'h3a, 6'h3b, 6'h3c, 6'h3d};

   // Command letters, none of them a five-bit data code of the nibble coder.
   localparam logic [4:0] LETTER_TABLE [4] = '{
      5'h1f, 5'h0d, 5'h19, 5'h04};

   // A special group in a six-bit slot gets two leading zeros, which no
   // six-bit data code has.
   function automatic logic [5:0] wide_group(input logic [4:0] g);
      return {2'b00, g[3:0]};
   endfunction

   function automatic logic [3:0] code_len(input width_t w);
      case (w)
         WIDTH_9:  return LEN_9;
         WIDTH_10: return LEN_10;
         default:  return LEN_8;
      endcase
   endfunction

   function automatic logic [3:0] cmd_field(input width_t w,
                                            input logic [11:0] ln);
      case (w)
         WIDTH_9:  return {1'b0, ln[11:9]};
         WIDTH_10: return {2'b00, ln[11:10]};
         default:  return ln[11:8];
      endcase
   endfunction

   // Returns the code left-justified in twelve bits.
   function automatic logic [11:0] encode_word(input width_t w,
                                               input logic [11:0] ln,
                                               input logic sync);
      logic [3:0]  c;
      logic [4:0]  hs;
      logic [4:0]  ls;
      logic        special;
      logic [11:0] r;
      c       = cmd_field(w, ln);
      hs      = sync ? SYM_J : LETTER_TABLE[c[3:2]];
      ls      = sync ? SYM_K : LETTER_TABLE[c[1:0]];
      special = sync | (c != 4'h0);
      case (w)
         WIDTH_9:  r = special ? {wide_group(hs), ls, 1'b0}
                               : {ENC5_TABLE[ln[8:4]], ENC4_TABLE[ln[3:0]],
                                  1'b0};
         WIDTH_10: r = special ? {wide_group(hs), wide_group(ls)}
                               : {ENC5_TABLE[ln[8:4]],
                                  ENC5_TABLE[{ln[9], ln[3:0]}]};
         default:  r = special ? {hs, ls, 2'b00}
                               : {ENC4_TABLE[ln[7:4]], ENC4_TABLE[ln[3:0]],
                                  2'b00};
      endcase
      return r;
   endfunction

   function automatic logic [2:0] letter_idx(input logic [5:0] g,
                                             input logic wide);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (g == (wide ? wide_group(LETTER_TABLE[i])
                        : {1'b0, LETTER_TABLE[i]})) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [4:0] dec4(input logic [4:0] g);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (ENC4_TABLE[i] == g) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [5:0] dec5(input logic [5:0] g);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < 32; i++) begin
         if (ENC5_TABLE[i] == g) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   function automatic dec_t decode_word(input width_t w,
                                        input logic [11:0] lj);
      logic [5:0] hi;
      logic [5:0] lo;
      logic       wh;
      logic       wl;
      logic [2:0] lh;
      logic [2:0] ll;
      logic [4:0] d4h;
      logic [4:0] d4l;
      logic [5:0] d5h;
      logic [5:0] d5l;
      dec_t       r;
      wh  = (w == WIDTH_9) || (w == WIDTH_10);
      wl  = (w == WIDTH_10);
      hi  = wh ? lj[11:6] : {1'b0, lj[11:7]};
      lo  = wl ? lj[5:0] : (wh ? {1'b0, lj[5:1]} : {1'b0, lj[6:2]});
      lh  = letter_idx(hi, wh);
      ll  = letter_idx(lo, wl);
      d4h = dec4(hi[4:0]);
      d4l = dec4(lo[4:0]);
      d5h = dec5(hi);
      d5l = dec5(lo);
      r   = '0;
      if (lh[2] && ll[2]) begin
         r.word.is_cmd = 1'b1;
         case (w)
            WIDTH_9: begin
               r.ok         = !lh[1];
               r.word.lines = {lh[0], ll[1:0], 9'h000};
            end
            WIDTH_10: begin
               r.ok         = (lh[1:0] == 2'h0);
               r.word.lines = {ll[1:0], 10'h000};
            end
            default: begin
               r.ok         = 1'b1;
               r.word.lines = {lh[1:0], ll[1:0], 8'h00};
            end
         endcase
      end else begin
         case (w)
            WIDTH_9: begin
               r.ok         = d5h[5] & d4l[4];
               r.word.lines = {3'h0, d5h[4:0], d4l[3:0]};
            end
            WIDTH_10: begin
               r.ok         = d5h[5] & d5l[5];
               r.word.lines = {2'h0, d5l[4], d5h[4:0], d5l[3:0]};
            end
            default: begin
               r.ok         = d4h[4] & d4l[4];
               r.word.lines = {4'h0, d4h[3:0], d4l[3:0]};
            end
         endcase
      end
      return r;
   endfunction

endpackage

// >>> rx_bit_recovery.sv
`timescale 1ns/100ps
module rx_bit_recovery #(
   parameter int BIT_CYCLES = link_codec_pkg::BIT_CYCLES_DEFAULT
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Timing source selection
   input  wire logic test_mode,
   // Pins
   input  wire logic ser_pin,
   input  wire logic tick_pin,
   // Recovered bits
   output logic      bit_valid,
   output logic      bit_value,
   output logic      line_level
);
   import link_codec_pkg::*;

   localparam int             PW         = $clog2(BIT_CYCLES);
   localparam logic [PW-1:0] PHASE_LAST = PW'(BIT_CYCLES - 1);
   localparam logic [PW-1:0] PHASE_MID  = PW'(BIT_CYCLES / 2);

   if (BIT_CYCLES < 4) begin : g_bad_bit_cycles
      $error("BIT_CYCLES must be at least 4");
   end

   logic          ser_meta_q;
   logic          ser_sync_q;
   logic          ser_prev_q;
   logic          tick_meta_q;
   logic          tick_sync_q;
   logic          tick_prev_q;
   logic [PW-1:0] phase_q;
   logic [PW-1:0] phase_d;
   logic          level_q;
   logic          valid_q;
   logic          value_q;
   logic          edge_seen;
   logic          sample;

   // Any transition re-centres the sampling phase on the bit cell.
   assign edge_seen = ser_sync_q ^ ser_prev_q;
   assign phase_d   = (edge_seen || phase_q == PHASE_LAST) ? '0
                                                           : phase_q + 1'b1;
   // [RULE_12] external bit timing
   assign sample    = test_mode ? (tick_sync_q & ~tick_prev_q)
                                : (phase_q == PHASE_MID);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ser_meta_q  <= LINE_IDLE_LEVEL;
         ser_sync_q  <= LINE_IDLE_LEVEL;
         ser_prev_q  <= LINE_IDLE_LEVEL;
         tick_meta_q <= 1'b0;
         tick_sync_q <= 1'b0;
         tick_prev_q <= 1'b0;
         phase_q     <= '0;
         level_q     <= LINE_IDLE_LEVEL;
         valid_q     <= 1'b0;
         value_q     <= 1'b0;
      end else begin
         ser_meta_q  <= ser_pin;
         ser_sync_q  <= ser_meta_q;
         ser_prev_q  <= ser_sync_q;
         tick_meta_q <= tick_pin;
         tick_sync_q <= tick_meta_q;
         tick_prev_q <= tick_sync_q;
         phase_q     <= phase_d;
         level_q     <= sample ? ser_sync_q : level_q;
         valid_q     <= sample;
         // A change of level since the last sample is a one.
         value_q     <= sample ? (ser_sync_q ^ level_q) : value_q;
      end
   end

   assign bit_valid  = valid_q;
   assign bit_value  = value_q;
   assign line_level = ser_prev_q;

endmodule // rx_bit_recovery

// >>> serial_link_codec.sv
`timescale 1ns/100ps
// Overview of operation
// [RULE_01] Transmitter latches each host word, encodes it, shifts it out.
// [RULE_02] Eight-bit width: each nibble maps to its own five-bit code group.
// [RULE_03] The whole encoded byte leaves as an NRZI line stream.
// [RULE_04] Host strobes each word in; transmitter answers with acknowledge.
// [RULE_05] Data or command symbols go out only in slots the host strobed.
// [RULE_06] Every slot without a strobed word carries the unique sync symbol.
// [RULE_07] Receiver sets its byte boundaries from detected sync symbols.
// [RULE_08] A received sync never changes the held output word.
// [RULE_09] Receiver deserialises, decodes, presents each word with a strobe.
// [RULE_10] Twelve parallel lines split 8/4, 9/3 or 10/2 data and command.
// [RULE_11] Local and cascade link modes; cascade repeats the line downstream.
// [RULE_12] Test mode takes bit timing from external ticks, not dividers.
// [RULE_13] Any nonzero command bit sends a command symbol; data is ignored.
// [RULE_14] Nine-bit width uses a six-bit upper group; ten-bit uses two.
// [RULE_15] Serial bits leave most significant bit of the upper group first.
// [RULE_16] NRZI: a one toggles the line, a zero leaves it.
// [RULE_17] Width and mode stay fixed in operation and match at both ends.
module serial_link_codec #(
   parameter int BIT_CYCLES = link_codec_pkg::BIT_CYCLES_DEFAULT
) (
   // Clock and reset
   input  wire logic                                   CLK,
   input  wire logic                                   RESET_N,
   // Line configuration, held while the link runs
   input  wire link_codec_pkg::line_cfg_t              CFG,
   // Host transmit side
   input  wire logic [link_codec_pkg::LINE_COUNT-1:0] TX_LINES,
   input  wire logic                                   INPUT_WORD_STROBE,
   output logic                                        TX_ACK,
   // External bit timing for test mode
   input  wire logic                                   TEST_TX_TICK,
   input  wire logic                                   TEST_RX_TICK,
   // Serial medium
   output logic                                        SER_OUT,
   input  wire logic                                   SER_IN,
   output logic                                        CASCADE_OUT,
   // Host receive side
   output link_codec_pkg::rx_word_t                    RX_WORD,
   output logic                                        RX_STROBE,
   output logic                                        RX_VIOLATION,
   output logic                                        RX_FRAMED
);
   import link_codec_pkg::*;

   localparam int             PW       = $clog2(BIT_CYCLES);
   localparam logic [PW-1:0] DIV_LAST = PW'(BIT_CYCLES - 1);

   if (BIT_CYCLES < 4 || BIT_CYCLES > 256) begin : g_bad_bit_cycles
      $error("BIT_CYCLES must lie between 4 and 256");
   end

   logic          test_mode;
   logic [3:0]    slot_len;
   logic          ack_q;
   logic          full_q;
   logic [11:0]   latch_q;
   logic [PW-1:0] div_q;
   logic          ttk_meta_q;
   logic          ttk_sync_q;
   logic          ttk_prev_q;
   logic [11:0]   sh_q;
   logic [11:0]   sh_d;
   logic [3:0]    left_q;
   logic [3:0]    left_d;
   logic          line_q;
   logic          take;
   logic          tx_tick;
   logic          slot_end;
   logic          load;
   logic          load_data;
   logic          tx_bit;
   logic [11:0]   next_code;
   logic [11:0]   sync_code;
   logic          tx_cmd_nz;
   dec_t          tx_chk;

   assign test_mode = (CFG.mode == MODE_TEST);
   // [RULE_14] slot length by width
   assign slot_len  = code_len(CFG.width);

   // [RULE_04] four-phase handshake
   assign take      = INPUT_WORD_STROBE & ~ack_q & ~full_q;
   // [RULE_12] external bit timing
   assign tx_tick   = test_mode ? (ttk_sync_q & ~ttk_prev_q)
                                : (div_q == DIV_LAST);
   assign slot_end  = (left_q == 4'h0);
   assign load      = tx_tick & slot_end;
   // [RULE_05] only strobed words
   assign load_data = load & full_q;
   // [RULE_02] nibble code groups
   // [RULE_06] sync fills empty slots
   assign next_code = encode_word(CFG.width, latch_q, ~full_q);
   assign sync_code = encode_word(CFG.width, LINES_RESET, 1'b1);
   // [RULE_13] command check
   assign tx_cmd_nz = (cmd_field(CFG.width, latch_q) != 4'h0);
   assign tx_chk    = decode_word(CFG.width, next_code);
   // [RULE_15] upper group first
   assign tx_bit    = slot_end ? next_code[11] : sh_q[11];
   assign sh_d      = !tx_tick ? sh_q
                    : (slot_end ? {next_code[10:0], 1'b0}
                                : {sh_q[10:0], 1'b0});
   assign left_d    = !tx_tick ? left_q
                    : (slot_end ? slot_len - 4'h1 : left_q - 4'h1);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ack_q      <= 1'b0;
         full_q     <= 1'b0;
         latch_q    <= LINES_RESET;
         div_q      <= '0;
         ttk_meta_q <= 1'b0;
         ttk_sync_q <= 1'b0;
         ttk_prev_q <= 1'b0;
         sh_q       <= 12'h000;
         left_q     <= 4'h0;
         line_q     <= LINE_IDLE_LEVEL;
      end else begin
         ack_q      <= take | (ack_q & INPUT_WORD_STROBE);
         // [RULE_01] input latch
         full_q     <= take | (full_q & ~load_data);
         latch_q    <= take ? TX_LINES : latch_q;
         div_q      <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
         ttk_meta_q <= TEST_TX_TICK;
         ttk_sync_q <= ttk_meta_q;
         ttk_prev_q <= ttk_sync_q;
         sh_q       <= sh_d;
         left_q     <= left_d;
         // [RULE_03] NRZI line coding
         // [RULE_16] one toggles line
         line_q     <= line_q ^ (tx_tick & tx_bit);
      end
   end

   assign TX_ACK  = ack_q;
   assign SER_OUT = line_q;

   logic        bit_valid;
   logic        bit_value;
   logic        line_level;
   logic [11:0] rsh_q;
   logic [11:0] rsh_d;
   logic [11:0] len_mask;
   logic [11:0] sync_rj;
   logic [11:0] word_lj;
   logic [3:0]  rcnt_q;
   logic [3:0]  rcnt_d;
   logic        framed_q;
   logic        sync_hit;
   logic        word_done;
   dec_t        dec;
   rx_word_t    word_q;
   logic        strobe_q;
   logic        viol_q;
   logic        cascade_q;

   rx_bit_recovery #(
      .BIT_CYCLES (BIT_CYCLES)
   ) u_bit_recovery (
      .clk        (CLK),
      .reset_n    (RESET_N),
      .test_mode  (test_mode),
      .ser_pin    (SER_IN),
      .tick_pin   (TEST_RX_TICK),
      .bit_valid  (bit_valid),
      .bit_value  (bit_value),
      .line_level (line_level)
   );

   assign rsh_d     = bit_valid ? {rsh_q[10:0], bit_value} : rsh_q;
   assign len_mask  = ~(12'hfff << slot_len);
   assign sync_rj   = sync_code >> (CODE_BITS - slot_len);
   // [RULE_07] framing from sync
   assign sync_hit  = bit_valid & ((rsh_d & len_mask) == sync_rj);
   // [RULE_08] sync never strobes
   assign word_done = bit_valid & framed_q & ~sync_hit
                    & ((rcnt_q + 4'h1) == slot_len);
   assign word_lj   = rsh_d << (CODE_BITS - slot_len);
   // [RULE_10] split by width
   assign dec       = decode_word(CFG.width, word_lj);
   assign rcnt_d    = (sync_hit || word_done) ? 4'h0
                    : ((bit_valid && framed_q) ? rcnt_q + 4'h1 : rcnt_q);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rsh_q     <= 12'h000;
         rcnt_q    <= 4'h0;
         framed_q  <= 1'b0;
         word_q    <= '0;
         strobe_q  <= 1'b0;
         viol_q    <= 1'b0;
         cascade_q <= 1'b0;
      end else begin
         rsh_q     <= rsh_d;
         rcnt_q    <= rcnt_d;
         framed_q  <= framed_q | sync_hit;
         // [RULE_09] present decoded word
         word_q    <= (word_done && dec.ok) ? dec.word : word_q;
         strobe_q  <= word_done & dec.ok;
         viol_q    <= word_done & ~dec.ok;
         // [RULE_11] cascade repeater
         cascade_q <= (CFG.mode == MODE_CASCADE) & line_level;
      end
   end

   assign RX_WORD      = word_q;
   assign RX_STROBE    = strobe_q;
   assign RX_VIOLATION = viol_q;
   assign RX_FRAMED    = framed_q;
   assign CASCADE_OUT  = cascade_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   AST_ACK_RISE: assert property ( // [RULE_04]
      INPUT_WORD_STROBE && !TX_ACK && !full_q |=> TX_ACK && full_q)
      else $error("Strobe was not acknowledged.");
   AST_ACK_FALL: assert property ( // [RULE_04]
      TX_ACK && !INPUT_WORD_STROBE |=> !TX_ACK ##1 !TX_ACK)
      else $error("Acknowledge did not drop after the strobe.");
   AST_DATA_SLOT: assert property ( // [RULE_05]
      load_data |=> !full_q)
      else $error("Latched word was not sent in its slot.");
   AST_SYNC_IDLE: assert property ( // [RULE_06]
      load && !full_q |=> sh_q == {sync_code[10:0], 1'b0})
      else $error("Empty slot did not carry sync.");
   AST_SLOT_LEN: assert property ( // [RULE_14]
      load |=> left_q == slot_len - 4'h1)
      else $error("Slot length does not match the width.");
   AST_CMD_WINS: assert property ( // [RULE_13]
      load_data && tx_cmd_nz |-> tx_chk.word.is_cmd)
      else $error("Nonzero command bits did not send a command.");
   AST_SHIFT_ORDER: assert property ( // [RULE_15]
      tx_tick && !slot_end |=> sh_q[11] == $past(sh_q[10]))
      else $error("Bits left out of order.");
   AST_NRZI_ONE: assert property ( // [RULE_16]
      tx_tick && tx_bit |=> SER_OUT != $past(SER_OUT))
      else $error("A one bit did not toggle the line.");
   AST_NRZI_ZERO: assert property ( // [RULE_16]
      !(tx_tick && tx_bit) |=> $stable(SER_OUT))
      else $error("The line moved without a one bit.");
   AST_FRAME_SYNC: assert property ( // [RULE_07]
      sync_hit |=> RX_FRAMED && rcnt_q == 4'h0)
      else $error("Sync did not set the byte boundary.");
   AST_SYNC_HOLDS: assert property ( // [RULE_08]
      sync_hit |=> $stable(RX_WORD) && !RX_STROBE)
      else $error("Sync disturbed the output word.");
   AST_RX_STROBE: assert property ( // [RULE_09]
      RX_STROBE |-> $past(word_done) && !RX_VIOLATION)
      else $error("Output strobe without a decoded word.");
   AST_CASCADE_OFF: assert property ( // [RULE_11]
      CFG.mode != MODE_CASCADE |=> !CASCADE_OUT)
      else $error("Repeater active outside cascade mode.");

   COV_DATA_WORD: cover property (RX_STROBE && !RX_WORD.is_cmd);
   COV_CMD_WORD: cover property (RX_STROBE && RX_WORD.is_cmd);
   COV_BUSY: cover property (INPUT_WORD_STROBE && full_q && !TX_ACK);
   COV_VIOLATION: cover property (RX_VIOLATION);

endmodule // serial_link_codec

// >>> link_partner.sv
`timescale 1ns/100ps
module link_partner (
   // Clock and line from the near transmitter
   input  wire logic       clk,
   input  wire logic       line_in,
   // Medium delay in cycles and external timing enable
   input  wire logic [2:0] lag,
   input  wire logic       tick_run,
   // Line to the near receiver and external timing
   output logic            line_out,
   output logic            tx_tick,
   output logic            rx_tick
);
   logic [7:0] dly_q;
   logic [7:0] tk_q;

   initial begin
      dly_q = 8'h00;
      tk_q  = 8'h0f;
   end

   // Matched width both ends.
   // The line is looped back, so the near receiver always shares the width.
   // A plain process, so that the start-up values set above are legal.
   always @(posedge clk) begin
      dly_q <= {dly_q[6:0], line_in};
      tk_q  <= tick_run ? {tk_q[6:0], tk_q[7]} : tk_q;
   end

   assign line_out = dly_q[lag];
   // External bit timing.
   // Receive ticks lag by half a bit so sampling lands mid-bit.
   assign tx_tick = tk_q[0];
   assign rx_tick = tk_q[4];
endmodule // link_partner

// >>> serial_link_codec_tb_top.sv
`timescale 1ns/100ps
module serial_link_codec_tb_top;
   import link_codec_pkg::*;
   logic        clk;
   logic        reset_n;
   line_cfg_t   cfg;
   logic [11:0] tx_lines;
   logic        strobe;
   logic        tx_ack;
   logic        ser_out;
   logic        ser_in;
   logic        casc;
   logic        tx_tick;
   logic        rx_tick;
   logic [2:0]  lag;
   logic        tick_run;
   rx_word_t    rx_word;
   rx_word_t    got = '0;
   logic        rx_strobe;
   logic        rx_viol;
   logic        framed;
   logic [11:0] hist = '0;
   logic        prev = 1'b0;
   int          ph = 0;
   int          strobes = 0;
   int          viols = 0;
   int          fails = 0;
   int          check_count = 0;

   serial_link_codec #(.BIT_CYCLES(4)) uut (
      .CLK(clk), .RESET_N(reset_n), .CFG(cfg), .TX_LINES(tx_lines),
      .INPUT_WORD_STROBE(strobe), .TX_ACK(tx_ack), .TEST_TX_TICK(tx_tick),
      .TEST_RX_TICK(rx_tick), .SER_OUT(ser_out), .SER_IN(ser_in),
      .CASCADE_OUT(casc), .RX_WORD(rx_word), .RX_STROBE(rx_strobe),
      .RX_VIOLATION(rx_viol), .RX_FRAMED(framed));

   link_partner far_end (
      .clk(clk), .line_in(ser_out), .lag(lag), .tick_run(tick_run),
      .line_out(ser_in), .tx_tick(tx_tick), .rx_tick(rx_tick));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rx_strobe === 1'b1) begin
         strobes <= strobes + 1;
         got     <= rx_word;
      end
      if (rx_viol === 1'b1) viols <= viols + 1;
   end

   // One bit a period of four clocks, NRZI undone, newest bit lowest.
   always @(negedge clk) begin
      if (reset_n !== 1'b1) begin
         ph <= 0;
      end else begin
         ph <= (ph + 1) % 4;
         if (ph == 0) begin
            hist <= {hist[10:0], ser_out ^ prev};
            prev <= ser_out;
         end
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic pick(input int sel);
      return sel == 0 ? tx_ack : framed;
   endfunction

   task automatic await(input int sel, input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pick(sel) !== lvl && n < 600);
      if (n >= 600) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, pick(sel), lvl);
         complete_run();
      end
   endtask

   task automatic restart(input width_t w, input link_mode_t m,
                          input logic [2:0] l);
      reset_n  <= 1'b0;
      cfg      <= '{w, m};
      lag      <= l;
      tick_run <= (m == MODE_TEST);
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      await(1, 1'b1);
   endtask

   task automatic send(input logic [11:0] w, input int hold);
      tx_lines <= w;
      strobe   <= 1'b1;
      await(0, 1'b1);
      repeat (hold) @(posedge clk);
      strobe <= 1'b0;
      await(0, 1'b0);
   endtask

   task automatic expect_word(input int n0, input logic [12:0] exp);
      int n;
      n = 0;
      while (strobes == n0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      if (strobes == n0) begin
         check(16'(strobes - n0), 16'h1);
         complete_run();
      end
      check({3'h0, got}, {3'h0, exp});
   endtask

   task automatic seek(input logic [11:0] pat);
      int n;
      n = 0;
      while ((hist & 12'h3ff) !== pat && n < 400) begin
         @(negedge clk);
         n++;
      end
      check({4'h0, hist & 12'h3ff}, {4'h0, pat});
      if ((hist & 12'h3ff) !== pat) complete_run();
      @(posedge clk);
   endtask

   task automatic t_idle_wire();
      int n0;
      restart(WIDTH_8, MODE_LOCAL, 3'h0);
      n0 = strobes;
      seek(12'h311);
      check({15'h0, casc}, 16'h0);
      send(12'h000, 0);
      seek(12'h3de);
      expect_word(n0, 13'h0000);
   endtask

   task automatic t_commands();
      int n0;
      for (int c = 1; c < 16; c++) begin
         n0 = strobes;
         send({4'(c), 8'h5a}, 0);
         expect_word(n0, {1'b1, 4'(c), 8'h00});
      end
   endtask

   task automatic t_hold_b2b();
      int n0;
      rx_word_t keep;
      restart(WIDTH_8, MODE_LOCAL, 3'h7);
      n0 = strobes;
      send(12'h0c3, 30);
      send(12'h03c, 0);
      expect_word(n0, 13'h00c3);
      expect_word(n0 + 1, 13'h003c);
      keep = rx_word;
      repeat (300) @(posedge clk);
      check(16'(strobes - n0), 16'h2);
      check({3'h0, rx_word}, {3'h0, keep});
   endtask

   task automatic t_width(input width_t w, input logic [11:0] d,
                          input logic [11:0] c, input link_mode_t m);
      int n0;
      restart(w, m, 3'h2);
      n0 = strobes;
      send(d, 0);
      expect_word(n0, {1'b0, d});
      send(c | d, 0);
      expect_word(n0 + 1, {1'b1, c});
   endtask

   task automatic t_cascade();
      logic [3:0] sh;
      int bad;
      restart(WIDTH_8, MODE_CASCADE, 3'h5);
      sh  = 4'h0;
      bad = 0;
      // The repeater trails the medium by four edges: three sync stages
      // and its own register.
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         if (i >= 4 && casc !== sh[3]) bad++;
         sh = {sh[2:0], ser_in};
      end
      check(16'(bad), 16'h0);
   endtask

   initial begin
      reset_n  = 1'b0;
      cfg      = '{WIDTH_8, MODE_LOCAL};
      tx_lines = 12'h000;
      strobe   = 1'b0;
      lag      = 3'h0;
      tick_run = 1'b0;
      repeat (3) @(posedge clk);
      check({10'h0, tx_ack, ser_out, casc, rx_strobe, rx_viol, framed},
            16'h0);
      check({3'h0, rx_word}, 16'h0);
      t_idle_wire();
      t_commands();
      t_hold_b2b();
      t_width(WIDTH_9, 12'h1a5, 12'ha00, MODE_LOCAL);
      t_width(WIDTH_10, 12'h2c3, 12'hc00, MODE_LOCAL);
      t_cascade();
      t_width(WIDTH_8, 12'h096, 12'h700, MODE_CASCADE);
      t_width(WIDTH_8, 12'h0e1, 12'h900, MODE_TEST);
      check({15'h0, framed}, 16'h1);
      check(16'(viols), 16'h0);
      complete_run();
   end
endmodule // serial_link_codec_tb_top
